// ---- fcp_decode.sv ----
// Address to page decoder for CPU and SPI sides.
// Assumes combinational use inside the top module.
`default_nettype none

module fcp_decode
   import fcp_pkg::*;
(
   fcp_decode_if.dec d
);
   always_comb begin
      d.cpu_is_code = (d.cpu_addr < CPU_CODE_END);
      d.cpu_is_data = (d.cpu_addr >= CPU_EXT0_BASE);
      if (d.cpu_addr >= CPU_NRM1_BASE)
         d.cpu_page = PAGE_NRM1;
      else if (d.cpu_addr >= CPU_NRM0_BASE)
         d.cpu_page = PAGE_NRM0;
      else if (d.cpu_addr >= CPU_EXT1_BASE)
         d.cpu_page = PAGE_EXT1;
      else if (d.cpu_addr >= CPU_EXT0_BASE)
         d.cpu_page = PAGE_EXT0;
      else if (d.cpu_is_code)
         d.cpu_page = {3'h0, d.cpu_addr[13:9]};
      else
         d.cpu_page = PAGE_NONE;
      d.cpu_protected = d.cpu_is_code && (d.upp < CODE_PAGES) && (d.cpu_page >= d.upp);
   end

   always_comb begin
      d.spi_is_data  = (d.spi_addr >= SPI_NRM0_BASE) && (d.spi_addr < SPI_NRM_END);
      d.spi_in_range = (d.spi_addr < CPU_CODE_END) || d.spi_is_data;
      if (d.spi_addr >= SPI_NRM1_BASE && d.spi_is_data)
         d.spi_page = PAGE_NRM1;
      else if (d.spi_is_data)
         d.spi_page = PAGE_NRM0;
      else if (d.spi_addr < CPU_CODE_END)
         d.spi_page = {3'h0, d.spi_addr[13:9]};
      else
         d.spi_page = PAGE_NONE;
   end
endmodule : fcp_decode

`default_nettype wire

// ---- fcp_decode_if.sv ----
// Interface between the top module and its address decoder.
// Assumes both ends run on core_clk.
`default_nettype none

interface fcp_decode_if;
   import fcp_pkg::*;
   logic [15:0] cpu_addr;
   logic [15:0] spi_addr;
   logic [7:0]  upp;
   logic [7:0]  cpu_page;
   logic        cpu_is_code;
   logic        cpu_is_data;
   logic        cpu_protected;
   logic [7:0]  spi_page;
   logic        spi_is_data;
   logic        spi_in_range;
   modport top (output cpu_addr, spi_addr, upp,
                input cpu_page, cpu_is_code, cpu_is_data, cpu_protected,
                spi_page, spi_is_data, spi_in_range);
   modport dec (input cpu_addr, spi_addr, upp,
                output cpu_page, cpu_is_code, cpu_is_data, cpu_protected,
                spi_page, spi_is_data, spi_in_range);
endinterface : fcp_decode_if

`default_nettype wire

// ---- fcp_flash_model.sv ----
// Flash array partner: configuration page, top data bytes and SPI read pattern.
// Assumes same-cycle reads from fcp_top and single-cycle erase pulses from it.
`default_nettype none

module fcp_flash_model
   import fcp_pkg::*;
(
   // Clock
   input  wire logic        core_clk,
   // Read ports
   input  wire logic [8:0]  cfg_rd_addr,
   output logic [7:0]       cfg_rd_data,
   input  wire logic [15:0] top_rd_addr,
   output logic [7:0]       top_rd_data,
   input  wire logic [15:0] spi_addr,
   output logic [7:0]       spi_flash_rd_data,
   // Erase pulse
   input  wire logic        flash_erase_all
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] cfg_mem [512];
   logic [7:0] top_mem [16];

   assign cfg_rd_data       = cfg_mem[cfg_rd_addr];
   assign top_rd_data       = top_mem[top_rd_addr[3:0]];
   assign spi_flash_rd_data = spi_addr[7:0] ^ spi_addr[15:8] ^ 8'h5a;

   // programmer image, tuning kept, reserved erased
   task automatic load(input logic [7:0] upp, input logic [7:0] lock, input logic [7:0] dbg);
      for (int i = 0; i < 512; i++) begin
         cfg_mem[i] = (i < 32) ? 8'(i) : 8'hff;
      end
      cfg_mem[32] = upp;
      cfg_mem[35] = lock;
      cfg_mem[36] = dbg;
   endtask : load

   always @(posedge core_clk) begin
      if (flash_erase_all === 1'b1) begin
         for (int i = 0; i < 512; i++) begin
            cfg_mem[i] <= 8'hff;
         end
      end
   end
endmodule : fcp_flash_model

`default_nettype wire

// ---- fcp_pkg.sv ----
// Constants, types and mapping figures for the flash configuration and protection block.
// Assumes one 10 MHz clock and a single-cycle flash array model behind the ports.
//
// Contract
// - Two 256-byte data pages, CPU only.
// - Two 512-byte data pages, CPU and SPI.
// - Data page erase uses pages 32-35.
// - Load configuration page at every reset.
// - Copy unprotected page count at 0x20.
// - Readback lock blocks external main access.
// - Lock set once, cleared by erase all.
// - Debug byte not 0xFF enables debug.
// - Config page enable redirects SPI writes.
// - Protected pages read-only for CPU.
// - Pages at or above count are protected.
// - Boot select chooses start address.
// - Boot select is parity of top bytes.
// - Clear write enable after SPI operations; code clears it after accepted program, erase and lock only.
// - CPU command erases page below 36.
`default_nettype none

package fcp_pkg;
   // =====================================================================
   // Configuration page offsets
   localparam logic [8:0]  CFG_UPP_OFS      = 9'h020;
   localparam logic [8:0]  CFG_LOCK_OFS     = 9'h023;
   localparam logic [8:0]  CFG_DEBUG_OFS    = 9'h024;
   localparam logic [7:0]  CFG_ERASED       = 8'hff;
   // =====================================================================
   // Page figures
   localparam logic [7:0]  CODE_PAGES       = 8'h20;
   localparam logic [7:0]  PAGE_EXT0        = 8'h20;
   localparam logic [7:0]  PAGE_EXT1        = 8'h21;
   localparam logic [7:0]  PAGE_NRM0        = 8'h22;
   localparam logic [7:0]  PAGE_NRM1        = 8'h23;
   localparam logic [7:0]  PAGE_LIMIT       = 8'h24;
   localparam logic [7:0]  PAGE_NONE        = 8'hff;
   // =====================================================================
   // Address map
   localparam logic [15:0] CPU_EXT0_BASE    = 16'hfa00;
   localparam logic [15:0] CPU_EXT1_BASE    = 16'hfb00;
   localparam logic [15:0] CPU_NRM0_BASE    = 16'hfc00;
   localparam logic [15:0] CPU_NRM1_BASE    = 16'hfe00;
   localparam logic [15:0] SPI_NRM0_BASE    = 16'h4400;
   localparam logic [15:0] SPI_NRM1_BASE    = 16'h4600;
   localparam logic [15:0] SPI_NRM_END      = 16'h4800;
   localparam logic [15:0] CPU_CODE_END     = 16'h4000;
   localparam logic [15:0] CPU_DATA_END     = 16'hffff;
   localparam logic [15:0] BOOT_ADDR_ZERO   = 16'h0000;
   localparam int          PAGE_SHIFT       = 9;
   localparam logic [7:0]  TOP_BYTES        = 8'h10;
   localparam logic [15:0] TOP_FIRST_ADDR   = 16'hfff0;
   localparam logic [7:0]  RD_BLOCKED       = 8'h00;
   // =====================================================================
   // Boot loader states
   typedef enum logic [2:0] {
      FCP_LD_UPP, FCP_LD_LOCK, FCP_LD_DEBUG, FCP_LD_PARITY, FCP_LD_WAIT, FCP_RUN
   } fcp_boot_t;
   // SPI request kinds
   typedef enum logic [2:0] {
      FCP_SPI_READ, FCP_SPI_PROG, FCP_SPI_ERASE_PAGE, FCP_SPI_ERASE_ALL, FCP_SPI_LOCK,
      FCP_SPI_NOP
   } fcp_spi_op_t;
endpackage : fcp_pkg

`default_nettype wire

// ---- fcp_top.sv ----
// Flash configuration loader, protection and access gating.
// Assumes a flash array with one-cycle reads; requests are single-cycle pulses.
`default_nettype none

module fcp_top
   import fcp_pkg::*;
(
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst,
   // Configuration page read port
   output logic [8:0]        cfg_rd_addr,
   input  wire logic [7:0]  cfg_rd_data,
   // Data memory top bytes read port
   output logic [15:0]       top_rd_addr,
   input  wire logic [7:0]  top_rd_data,
   // CPU requests
   input  wire logic        cpu_wr,
   input  wire logic        cpu_cmd_wr,
   input  wire logic [15:0] cpu_addr,
   input  wire logic [7:0]  cpu_cmd_data,
   // SPI requests
   input  wire logic        spi_req,
   input  wire fcp_spi_op_t spi_op,
   input  wire logic [15:0] spi_addr,
   input  wire logic        spi_wen_set,
   input  wire logic        config_page_enable,
   input  wire logic [7:0]  spi_flash_rd_data,
   // Flash operation outputs
   output logic              flash_wr,
   output logic              flash_erase_page,
   output logic              flash_erase_all,
   output logic              flash_to_cfg,
   output logic [7:0]        flash_page,
   output logic [15:0]       flash_addr,
   output logic              lock_write,
   // SPI answer
   output logic              spi_ack,
   output logic              spi_refused,
   output logic [7:0]        spi_rd_data,
   // Status
   output logic              ready_n,
   output logic              boot_select,
   output logic [15:0]       boot_addr,
   output logic [7:0]        protection_config_register,
   output logic              readback_lock,
   output logic              debug_enable,
   output logic              write_enable
);
   // =====================================================================
   // Decoder
   fcp_decode_if dif ();
   assign dif.cpu_addr = cpu_addr;
   assign dif.spi_addr = spi_addr;
   assign dif.upp      = protection_config_register;
   fcp_decode u_dec (.d(dif.dec));

   // =====================================================================
   // Boot sequence state
   fcp_boot_t   st_reg, st_next;
   logic [7:0]  upp_reg, upp_next;
   logic        lock_reg, lock_next;
   logic        dbg_reg, dbg_next;
   logic        par_reg, par_next;
   logic [7:0]  cnt_reg, cnt_next;
   logic        rdy_n_reg, rdy_n_next;
   logic [8:0]  cfga_reg, cfga_next;
   logic [15:0] topa_reg, topa_next;
   logic        lock_cmd_ok;
   logic        erase_all_ok;

   always_comb begin
      st_next    = st_reg;
      upp_next   = upp_reg;
      lock_next  = lock_reg;
      dbg_next   = dbg_reg;
      par_next   = par_reg;
      cnt_next   = cnt_reg;
      rdy_n_next = rdy_n_reg;
      cfga_next  = cfga_reg;
      topa_next  = topa_reg;
      case (st_reg)
         FCP_LD_UPP: begin
            upp_next  = cfg_rd_data;
            cfga_next = CFG_LOCK_OFS;
            st_next   = FCP_LD_LOCK;
         end
         FCP_LD_LOCK: begin
            lock_next = (cfg_rd_data != CFG_ERASED);
            cfga_next = CFG_DEBUG_OFS;
            st_next   = FCP_LD_DEBUG;
         end
         FCP_LD_DEBUG: begin
            dbg_next  = (cfg_rd_data != CFG_ERASED);
            topa_next = TOP_FIRST_ADDR;
            cnt_next  = 8'h00;
            st_next   = FCP_LD_PARITY;
         end
         FCP_LD_PARITY: begin
            par_next  = par_reg ^ (^top_rd_data);
            topa_next = topa_reg + 16'h0001;
            cnt_next  = cnt_reg + 8'h01;
            if (cnt_reg == TOP_BYTES - 8'h01)
               st_next = FCP_LD_WAIT;
         end
         FCP_LD_WAIT: begin
            rdy_n_next = 1'b0;
            st_next    = FCP_RUN;
         end
         FCP_RUN: begin
            // Lock set once, erase all clears
            if (erase_all_ok)
               lock_next = 1'b0;
            else if (lock_cmd_ok)
               lock_next = 1'b1;
         end
         default: st_next = FCP_LD_UPP;
      endcase
      if (!rdy_n_reg && erase_all_ok)
         dbg_next = 1'b0;
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         st_reg    <= FCP_LD_UPP;
         upp_reg   <= CFG_ERASED;
         lock_reg  <= 1'b1;
         dbg_reg   <= 1'b0;
         par_reg   <= 1'b0;
         cnt_reg   <= 8'h00;
         rdy_n_reg <= 1'b1;
         cfga_reg  <= CFG_UPP_OFS;
         topa_reg  <= TOP_FIRST_ADDR;
      end else begin
         st_reg    <= st_next;
         upp_reg   <= upp_next;
         lock_reg  <= lock_next;
         dbg_reg   <= dbg_next;
         par_reg   <= par_next;
         cnt_reg   <= cnt_next;
         rdy_n_reg <= rdy_n_next;
         cfga_reg  <= cfga_next;
         topa_reg  <= topa_next;
      end
   end

   // =====================================================================
   // Access gating
   logic        spi_go;
   logic        spi_blocked;
   logic        wen_reg, wen_next;
   logic        fwr_reg, fwr_next, fep_reg, fep_next, fea_reg, fea_next;
   logic        fcfg_reg, fcfg_next, lkw_reg, lkw_next;
   logic [7:0]  fpg_reg, fpg_next;
   logic [15:0] fad_reg, fad_next;
   logic        ack_reg, ack_next, ref_reg, ref_next;
   logic [7:0]  rdd_reg, rdd_next;

   assign spi_go       = spi_req && (st_reg == FCP_RUN);
   assign erase_all_ok = spi_go && (spi_op == FCP_SPI_ERASE_ALL) && wen_reg;
   assign lock_cmd_ok  = spi_go && (spi_op == FCP_SPI_LOCK) && wen_reg && !lock_reg;

   always_comb begin
      case (spi_op)
         FCP_SPI_READ:       spi_blocked = lock_reg && !config_page_enable;
         FCP_SPI_PROG,
         FCP_SPI_ERASE_PAGE: spi_blocked = lock_reg || !wen_reg ||
                                           (!config_page_enable && !dif.spi_in_range);
         FCP_SPI_ERASE_ALL:  spi_blocked = !wen_reg;
         FCP_SPI_LOCK:       spi_blocked = !wen_reg || lock_reg;
         default:            spi_blocked = 1'b1;
      endcase
   end

   always_comb begin
      fwr_next  = 1'b0;
      fep_next  = 1'b0;
      fea_next  = 1'b0;
      fcfg_next = 1'b0;
      lkw_next  = 1'b0;
      fpg_next  = fpg_reg;
      fad_next  = fad_reg;
      ack_next  = 1'b0;
      ref_next  = 1'b0;
      rdd_next  = rdd_reg;
      wen_next  = wen_reg;
      if (spi_wen_set)
         wen_next = 1'b1;
      if (spi_go) begin
         ack_next = !spi_blocked;
         ref_next = spi_blocked;
         fad_next = spi_addr;
         rdd_next = spi_blocked ? RD_BLOCKED : spi_flash_rd_data;
         if (!spi_blocked) begin
            case (spi_op)
               FCP_SPI_PROG: begin
                  fwr_next  = 1'b1;
                  fcfg_next = config_page_enable;
               end
               FCP_SPI_ERASE_PAGE: begin
                  fep_next  = 1'b1;
                  fcfg_next = config_page_enable;
                  fpg_next  = dif.spi_page;
               end
               FCP_SPI_ERASE_ALL: begin
                  fea_next  = 1'b1;
                  fcfg_next = 1'b1;
               end
               FCP_SPI_LOCK: lkw_next = 1'b1;
               default: ;
            endcase
         end
         // Clear latch after SPI write, erase or lock
         if (!spi_blocked && spi_op != FCP_SPI_READ)
            wen_next = 1'b0;
      end else if (st_reg == FCP_RUN && cpu_cmd_wr) begin
         fpg_next = cpu_cmd_data;
         fep_next = (cpu_cmd_data < PAGE_LIMIT) &&
                    !((upp_reg < CODE_PAGES) && (cpu_cmd_data >= upp_reg) &&
                      (cpu_cmd_data < CODE_PAGES));
      end else if (st_reg == FCP_RUN && cpu_wr) begin
         fad_next = cpu_addr;
         fpg_next = dif.cpu_page;
         fwr_next = (dif.cpu_is_code || dif.cpu_is_data) && !dif.cpu_protected;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         wen_reg  <= 1'b0;
         fwr_reg  <= 1'b0;
         fep_reg  <= 1'b0;
         fea_reg  <= 1'b0;
         fcfg_reg <= 1'b0;
         lkw_reg  <= 1'b0;
         fpg_reg  <= 8'h00;
         fad_reg  <= 16'h0000;
         ack_reg  <= 1'b0;
         ref_reg  <= 1'b0;
         rdd_reg  <= 8'h00;
      end else begin
         wen_reg  <= wen_next;
         fwr_reg  <= fwr_next;
         fep_reg  <= fep_next;
         fea_reg  <= fea_next;
         fcfg_reg <= fcfg_next;
         lkw_reg  <= lkw_next;
         fpg_reg  <= fpg_next;
         fad_reg  <= fad_next;
         ack_reg  <= ack_next;
         ref_reg  <= ref_next;
         rdd_reg  <= rdd_next;
      end
   end

   logic [15:0] boot_reg;
   always_ff @(posedge core_clk) begin
      if (rst)
         boot_reg <= BOOT_ADDR_ZERO;
      else
         boot_reg <= (par_reg && upp_reg < CODE_PAGES) ?
                     {upp_reg[6:0], 9'h000} : BOOT_ADDR_ZERO;
   end

   assign cfg_rd_addr                = cfga_reg;
   assign top_rd_addr                = topa_reg;
   assign flash_wr                   = fwr_reg;
   assign flash_erase_page           = fep_reg;
   assign flash_erase_all            = fea_reg;
   assign flash_to_cfg               = fcfg_reg;
   assign flash_page                 = fpg_reg;
   assign flash_addr                 = fad_reg;
   assign lock_write                 = lkw_reg;
   assign spi_ack                    = ack_reg;
   assign spi_refused                = ref_reg;
   assign spi_rd_data                = rdd_reg;
   assign ready_n                    = rdy_n_reg;
   assign boot_select                = par_reg;
   assign boot_addr                  = boot_reg;
   assign protection_config_register = upp_reg;
   assign readback_lock              = lock_reg;
   assign debug_enable               = dbg_reg;
   assign write_enable               = wen_reg;

   // =====================================================================
   // Checks
   boot_len_a: assert property (@(posedge core_clk) disable iff (rst)
      $rose(st_reg == FCP_LD_PARITY) |-> ##16 (st_reg == FCP_LD_WAIT))
      else $error("boot parity length wrong");
   wen_clr_a: assert property (@(posedge core_clk) disable iff (rst)
      (spi_go && !spi_blocked && spi_op != FCP_SPI_READ) |=> !wen_reg)
      else $error("write enable not cleared");
   lock_blk_a: assert property (@(posedge core_clk) disable iff (rst)
      (spi_go && lock_reg && spi_op == FCP_SPI_PROG) |=> (spi_refused && !flash_wr))
      else $error("locked program not refused");
   lock_rd_a: assert property (@(posedge core_clk) disable iff (rst)
      spi_refused |-> (spi_rd_data == RD_BLOCKED))
      else $error("refused read leaks data");
   prot_wr_a: assert property (@(posedge core_clk) disable iff (rst)
      (st_reg == FCP_RUN && cpu_wr && !spi_req && dif.cpu_protected) |=> !flash_wr)
      else $error("protected page written");
   cmd_rng_a: assert property (@(posedge core_clk) disable iff (rst)
      (st_reg == FCP_RUN && cpu_cmd_wr && !spi_req && cpu_cmd_data >= PAGE_LIMIT)
      |=> !flash_erase_page)
      else $error("out of range page erased");
   unlock_a: assert property (@(posedge core_clk) disable iff (rst)
      erase_all_ok |=> !readback_lock)
      else $error("erase all left lock");
   cfg_dir_a: assert property (@(posedge core_clk) disable iff (rst)
      (spi_go && !spi_blocked && spi_op == FCP_SPI_PROG) |=> (flash_to_cfg ==
      $past(config_page_enable)))
      else $error("config redirect wrong");
   boot_a: assert property (@(posedge core_clk) disable iff (rst)
      (!boot_select && st_reg == FCP_RUN) |=> (boot_addr == BOOT_ADDR_ZERO))
      else $error("boot address not zero");
   ready_c: cover property (@(posedge core_clk) disable iff (rst) $fell(ready_n));
   lock_c: cover property (@(posedge core_clk) disable iff (rst) $rose(readback_lock));
   eall_c: cover property (@(posedge core_clk) disable iff (rst) flash_erase_all);
   prot_c: cover property (@(posedge core_clk) disable iff (rst)
      cpu_wr && dif.cpu_protected);
endmodule : fcp_top

`default_nettype wire

// ---- tb_flash_config_protection.sv ----
// Self-checking bench for the flash configuration and protection block.
// Assumes fcp_pkg, the decoder, fcp_top and fcp_flash_model are compiled before it.
`default_nettype none

module tb_flash_config_protection
   import fcp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   // =====================================================================
   // Signals
   logic        core_clk, rst, cpu_wr, cpu_cmd_wr, spi_req, spi_wen_set;
   logic        config_page_enable, flash_wr, flash_erase_page, flash_erase_all;
   logic        flash_to_cfg, lock_write, spi_ack, spi_refused, ready_n;
   logic        boot_select, readback_lock, debug_enable, write_enable;
   logic [8:0]  cfg_rd_addr;
   logic [7:0]  cfg_rd_data, top_rd_data, cpu_cmd_data, spi_flash_rd_data;
   logic [7:0]  flash_page, spi_rd_data, protection_config_register, m_upp;
   logic [15:0] top_rd_addr, cpu_addr, spi_addr, flash_addr, boot_addr;
   fcp_spi_op_t spi_op;
   logic        m_lock, m_wen, m_dbg;
   int          fail_count, cmp_count, seed;
   logic [15:0] addr_tab [6] = '{16'h1600, 16'h1800, 16'h3e00, 16'hfa00, 16'hfc00, 16'h5000};
   logic [7:0]  cmd_tab [9] = '{8'h0b, 8'h0c, 8'h1f, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'hff};

   initial core_clk = 1'b0;
   always #50 core_clk = ~core_clk;

   fcp_top DUT (.core_clk(core_clk), .rst(rst), .cfg_rd_addr(cfg_rd_addr),
      .cfg_rd_data(cfg_rd_data), .top_rd_addr(top_rd_addr), .top_rd_data(top_rd_data),
      .cpu_wr(cpu_wr), .cpu_cmd_wr(cpu_cmd_wr), .cpu_addr(cpu_addr),
      .cpu_cmd_data(cpu_cmd_data), .spi_req(spi_req), .spi_op(spi_op), .spi_addr(spi_addr),
      .spi_wen_set(spi_wen_set), .config_page_enable(config_page_enable),
      .spi_flash_rd_data(spi_flash_rd_data), .flash_wr(flash_wr),
      .flash_erase_page(flash_erase_page), .flash_erase_all(flash_erase_all),
      .flash_to_cfg(flash_to_cfg), .flash_page(flash_page), .flash_addr(flash_addr),
      .lock_write(lock_write), .spi_ack(spi_ack), .spi_refused(spi_refused),
      .spi_rd_data(spi_rd_data), .ready_n(ready_n), .boot_select(boot_select),
      .boot_addr(boot_addr), .protection_config_register(protection_config_register),
      .readback_lock(readback_lock), .debug_enable(debug_enable), .write_enable(write_enable));

   fcp_flash_model P (.core_clk(core_clk), .cfg_rd_addr(cfg_rd_addr), .cfg_rd_data(cfg_rd_data),
      .top_rd_addr(top_rd_addr), .top_rd_data(top_rd_data), .spi_addr(spi_addr),
      .spi_flash_rd_data(spi_flash_rd_data), .flash_erase_all(flash_erase_all));

   // =====================================================================
   // Checking and stimulus tasks
   task automatic print_verdict;
      if (fail_count == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : print_verdict

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk

   function automatic logic [15:0] rnd9();
      return 16'($random(seed)) & 16'h01ff;
   endfunction : rnd9

   task automatic boot(input logic [7:0] upp, input logic [7:0] lock, input logic [7:0] dbg,
                       input logic odd);
      int   n;
      logic par;
      rst = 1'b1;
      P.load(upp, lock, dbg);
      par = 1'b0;
      for (int i = 0; i < 16; i++) begin
         P.top_mem[i] = 8'($random(seed));
         par ^= ^P.top_mem[i];
      end
      if (par != odd) P.top_mem[0][0] = ~P.top_mem[0][0];
      repeat (3) @(negedge core_clk);
      rst = 1'b0;
      m_upp = upp;
      m_lock = (lock != 8'hff);
      m_dbg = (dbg != 8'hff);
      m_wen = 1'b0;
      n = 0;
      while (ready_n !== 1'b0 && n < 40) begin
         @(negedge core_clk);
         n++;
      end
      chk(16'(n), 16'd20, "boot length");
      chk(16'(protection_config_register), 16'(upp), "page count");
      chk(16'({boot_select, readback_lock, debug_enable, write_enable}),
          16'({odd, m_lock, m_dbg, 1'b0}), "boot flags");
      chk(boot_addr, (odd && upp < 8'h20) ? 16'(upp) << 9 : 16'h0000, "boot address");
      if (n >= 40) print_verdict();
   endtask : boot

   task automatic set_wen();
      spi_wen_set = 1'b1;
      @(negedge core_clk);
      spi_wen_set = 1'b0;
      m_wen = 1'b1;
   endtask : set_wen

   task automatic cpu_op(input logic cmd, input logic [15:0] v);
      logic ok;
      if (cmd) begin
         cpu_cmd_wr = 1'b1;
         cpu_cmd_data = v[7:0];
         ok = v < 16'd36 && !(v < 16'd32 && v >= 16'(m_upp));
      end else begin
         cpu_wr = 1'b1;
         cpu_addr = v;
         ok = v >= 16'hfa00 || (v < 16'h4000 && (v >> 9) < 16'(m_upp));
      end
      @(negedge core_clk);
      cpu_wr = 1'b0;
      cpu_cmd_wr = 1'b0;
      chk(16'({flash_wr, flash_erase_page}), 16'({ok && !cmd, ok && cmd}), "cpu op");
      if (ok) chk(cmd ? 16'(flash_page) : flash_addr, v, "cpu target");
      chk(16'(write_enable), 16'(m_wen), "cpu keeps latch");
   endtask : cpu_op

   task automatic spi_cmd(input fcp_spi_op_t op, input logic [15:0] a, input logic wen);
      logic        ok, rng;
      logic [5:0]  e, g;
      logic [15:0] pg;
      if (wen) set_wen();
      rng = config_page_enable || a < 16'h4000 || (a >= 16'h4400 && a < 16'h4800);
      pg = (a < 16'h4000) ? a >> 9 : ((a < 16'h4600) ? 16'h0022 : 16'h0023);
      case (op)
         FCP_SPI_READ:      ok = !(m_lock && !config_page_enable);
         FCP_SPI_ERASE_ALL: ok = m_wen;
         FCP_SPI_LOCK:      ok = m_wen && !m_lock;
         default:           ok = m_wen && !m_lock && rng;
      endcase
      e = {ok, !ok, ok && op == FCP_SPI_PROG, ok && op == FCP_SPI_ERASE_PAGE,
           ok && op == FCP_SPI_ERASE_ALL, ok && op == FCP_SPI_LOCK};
      spi_req = 1'b1;
      spi_op = op;
      spi_addr = a;
      @(negedge core_clk);
      spi_req = 1'b0;
      g = {spi_ack, spi_refused, flash_wr, flash_erase_page, flash_erase_all, lock_write};
      chk(16'(g), 16'(e), "spi pulses");
      if (op == FCP_SPI_READ)
         chk(16'(spi_rd_data), ok ? 16'(a[7:0] ^ a[15:8] ^ 8'h5a) : 16'h0000, "read");
      if (!ok || op == FCP_SPI_READ) return;
      if (op == FCP_SPI_PROG) chk(flash_addr, a, "prog address");
      if (op == FCP_SPI_ERASE_PAGE) chk(16'(flash_page), pg, "erase page");
      if (op != FCP_SPI_LOCK)
         chk(16'(flash_to_cfg), 16'(config_page_enable || op == FCP_SPI_ERASE_ALL),
             "target page");
      m_wen = 1'b0;
      if (op == FCP_SPI_ERASE_ALL) m_lock = 1'b0;
      if (op == FCP_SPI_ERASE_ALL) m_dbg = 1'b0;
      if (op == FCP_SPI_LOCK) m_lock = 1'b1;
      chk(16'({write_enable, readback_lock, debug_enable}), 16'({m_wen, m_lock, m_dbg}),
          "status");
   endtask : spi_cmd

   // =====================================================================
   // Main sequence
   initial begin
      seed = 94741;
      fail_count = 0;
      cmp_count = 0;
      {rst, cpu_wr, cpu_cmd_wr, spi_req, spi_wen_set, config_page_enable} = 6'h01 << 5;
      {cpu_addr, spi_addr, cpu_cmd_data} = 40'h0;
      spi_op = FCP_SPI_NOP;
      boot(8'd12, 8'hff, 8'h00, 1'b1);
      for (int i = 0; i < 6; i++) cpu_op(1'b0, addr_tab[i] | rnd9());
      for (int i = 0; i < 9; i++) cpu_op(1'b1, 16'(cmd_tab[i]));
      spi_cmd(FCP_SPI_PROG, 16'h0100, 1'b0);
      spi_cmd(FCP_SPI_PROG, 16'h4400 | rnd9(), 1'b1);
      spi_cmd(FCP_SPI_ERASE_PAGE, 16'h4600 | rnd9(), 1'b1);
      set_wen();
      cpu_op(1'b0, 16'h0020);
      spi_cmd(FCP_SPI_ERASE_PAGE, 16'h3e00, 1'b0);
      spi_cmd(FCP_SPI_PROG, 16'hfa00, 1'b1);
      spi_cmd(FCP_SPI_READ, rnd9(), 1'b0);
      config_page_enable = 1'b1;
      spi_cmd(FCP_SPI_PROG, 16'h0040, 1'b1);
      spi_cmd(FCP_SPI_ERASE_PAGE, 16'h0000, 1'b1);
      config_page_enable = 1'b0;
      spi_cmd(FCP_SPI_LOCK, 16'h0000, 1'b1);
      spi_cmd(FCP_SPI_READ, rnd9(), 1'b0);
      spi_cmd(FCP_SPI_PROG, 16'h0200, 1'b1);
      spi_cmd(FCP_SPI_LOCK, 16'h0000, 1'b1);
      config_page_enable = 1'b1;
      spi_cmd(FCP_SPI_READ, 16'h0023, 1'b0);
      spi_cmd(FCP_SPI_ERASE_PAGE, 16'h0000, 1'b1);
      config_page_enable = 1'b0;
      spi_cmd(FCP_SPI_ERASE_ALL, 16'h0000, 1'b1);
      spi_cmd(FCP_SPI_ERASE_ALL, 16'h0000, 1'b0);
      spi_cmd(FCP_SPI_READ, rnd9(), 1'b0);
      boot(8'd31, 8'hff, 8'hff, 1'b1);
      cpu_op(1'b0, 16'h3c00 | rnd9());
      cpu_op(1'b0, 16'h3e00 | rnd9());
      cpu_op(1'b1, 16'h001f);
      boot(8'hff, 8'h5a, 8'hff, 1'b0);
      cpu_op(1'b0, 16'h3e00 | rnd9());
      spi_cmd(FCP_SPI_READ, rnd9(), 1'b0);
      print_verdict();
   end

   initial begin
      #3000000;
      fail_count++;
      print_verdict();
   end
endmodule : tb_flash_config_protection

`default_nettype wire
